// *** verilog/ebpm_top.sv ***
// Top of the external bus pin-function multiplexer: owner arbitration and pin registers.
// Assumes the board wires each device to the shared pins for its width and kind.
`timescale 1ns/1ps
module ebpm_top
    import ebpm_pkg::*;
(
    input  wire logic           CLK,
    input  wire logic           RST_N,
    input  ebpm_smc_type        SMC_IN,
    input  ebpm_sdr_type        SDR_IN,
    input  ebpm_nand_type       NAND_IN,
    input  wire logic           SDR_REFRESH,
    input  wire logic [31:0]    SMC_WDATA,
    input  wire logic [31:0]    SDR_WDATA,
    input  wire logic           SMC_DOE,
    input  wire logic           SDR_DOE,
    input  wire logic [31:0]    D_IN,
    output logic [31:0]         D_OUT,
    output logic                D_OE,
    output logic [31:0]         RDATA,
    output ebpm_pins_type       PINS,
    output logic                SMC_STALL
);
    import ebpm_pkg::*;

    ebpm_owner_type owner;
    logic           gap;
    logic [25:0]    st_a;
    logic           st_wr0_n, st_wr1_n, st_wr3_n, st_ce1_n, st_ce2_n;
    ebpm_pins_type  pins_reg, pins_next;
    logic [31:0]    dout_reg, dout_next;
    logic           doe_reg, doe_next;
    logic [31:0]    rdata_reg, rdata_next;
    logic           sdr_access;

    // ------------------------------------------------------------------
    // Owner arbitration and static routing
    // ------------------------------------------------------------------
    ebpm_owner u_owner (
        .CLK        (CLK),
        .RST_N      (RST_N),
        .smc_active (SMC_IN.active),
        .sdr_active (sdr_access),
        .owner      (owner),
        .gap        (gap)
    );

    ebpm_route u_route (
        .static_mem_ctrl     (SMC_IN),
        .nand_in (NAND_IN),
        .a       (st_a),
        .wr0_n   (st_wr0_n),
        .wr1_n   (st_wr1_n),
        .wr3_n   (st_wr3_n),
        .ce1_n   (st_ce1_n),
        .ce2_n   (st_ce2_n)
    );

    // Refresh is a command with CS only; it needs no data lanes
    assign sdr_access = SDR_IN.active & ~SDR_REFRESH;
    // Static waits only during the float gap or an SDRAM data access
    assign SMC_STALL  = gap | (owner == OWN_SDRAM);

    // ------------------------------------------------------------------
    // Pin values per owner
    // ------------------------------------------------------------------
    always_comb begin
        pins_next = pins_reg;
        dout_next = dout_reg;
        doe_next  = 1'b0;
        rdata_next = rdata_reg;
        // SDRAM chip select passes straight unless static owns the lanes and SDRAM is idle
        pins_next.cs_n[PIN_SDRAM_CS] = SDR_IN.cs_n;
        if (owner == OWN_SDRAM && !gap) begin
            pins_next.a[10:2]    = SDR_IN.addr[8:0];
            pins_next.a[11]      = SDR_IN.addr[9];
            pins_next.sdram_addr_ten      = SDR_IN.addr[10];
            pins_next.a[14:13]   = SDR_IN.addr[12:11];
            pins_next.a[PIN_BA0] = SDR_IN.bank[0];
            pins_next.a[PIN_BA1] = SDR_IN.bank[1];
            pins_next.a[0]       = SDR_IN.dqm[0];
            pins_next.wr1_n      = SDR_IN.dqm[1];
            pins_next.a[1]       = SDR_IN.dqm[2];
            pins_next.wr3_n      = SDR_IN.dqm[3];
            dout_next            = SDR_WDATA;
            doe_next             = SDR_DOE;
            rdata_next           = D_IN;
        end else if (owner == OWN_STATIC && !gap && SMC_IN.active) begin
            pins_next.a         = st_a;
            pins_next.cs_n[0]   = SMC_IN.cs_n[0];
            pins_next.cs_n[2]   = SMC_IN.cs_n[2];
            pins_next.cs_n[7:3] = SMC_IN.cs_n[7:3];
            if (SDR_IN.cs_n && !SDR_IN.active) begin
                pins_next.cs_n[PIN_SDRAM_CS] = SMC_IN.cs_n[PIN_SDRAM_CS];
            end
            pins_next.rd_n      = (SMC_IN.dev == DEV_CARDIDE) ? 1'b1 : SMC_IN.rd_n;
            pins_next.wr0_n     = st_wr0_n;
            pins_next.wr1_n     = st_wr1_n;
            pins_next.wr3_n     = st_wr3_n;
            pins_next.ce1_n     = st_ce1_n;
            pins_next.ce2_n     = st_ce2_n;
            pins_next.nand_oe_n = (SMC_IN.dev == DEV_NAND) ? NAND_IN.re_n : 1'b1;
            pins_next.nand_we_n = (SMC_IN.dev == DEV_NAND) ? NAND_IN.we_n : 1'b1;
            dout_next           = SMC_WDATA;
            doe_next            = SMC_DOE;
            rdata_next          = D_IN;
        end else begin
            // Idle: strobes released except wr1_n/wr3_n, which hold while SDRAM owns the pins; address held
            pins_next.cs_n      = {CS_IDLE[7:2], SDR_IN.cs_n, CS_IDLE[0]};
            pins_next.rd_n      = 1'b1;
            pins_next.wr0_n     = 1'b1;
            pins_next.wr1_n     = (owner == OWN_SDRAM) ? pins_reg.wr1_n : 1'b1;
            pins_next.wr3_n     = (owner == OWN_SDRAM) ? pins_reg.wr3_n : 1'b1;
            pins_next.ce1_n     = 1'b1;
            pins_next.ce2_n     = 1'b1;
            pins_next.nand_oe_n = 1'b1;
            pins_next.nand_we_n = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pins_reg <= '{a: 26'h0, sdram_addr_ten: 1'b0, cs_n: 8'hff, rd_n: 1'b1, wr0_n: 1'b1,
                          wr1_n: 1'b1, wr3_n: 1'b1, nand_oe_n: 1'b1, nand_we_n: 1'b1,
                          ce1_n: 1'b1, ce2_n: 1'b1};
            dout_reg  <= 32'h0;
            doe_reg   <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            pins_reg  <= pins_next;
            dout_reg  <= dout_next;
            doe_reg   <= doe_next;
            rdata_reg <= rdata_next;
        end
    end

    assign PINS  = pins_reg;
    assign D_OUT = dout_reg;
    assign D_OE  = doe_reg;
    assign RDATA = rdata_reg;
endmodule

// *** verilog/ebpm_pkg.sv ***
// Package of the external bus pin-function multiplexer: modes, pin indices, carriers.
// Assumes the internal controllers present active-low strobes and byte-addressed buses.
package ebpm_pkg;

    // ------------------------------------------------------------------
    // Device kinds on the active access
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        DEV_S8     = 4'h0,
        DEV_S2X8   = 4'h1,
        DEV_S16    = 4'h2,
        DEV_S4X8   = 4'h3,
        DEV_S2X16  = 4'h4,
        DEV_S32    = 4'h5,
        DEV_SDRAM  = 4'h6,
        DEV_NAND   = 4'h7,
        DEV_CARD   = 4'h8,
        DEV_CARDIDE = 4'h9
    } ebpm_dev_type;

    // Pin owner state
    typedef enum logic [1:0] {
        OWN_STATIC = 2'h0,
        OWN_SDRAM  = 2'h1
    } ebpm_owner_type;

    // ------------------------------------------------------------------
    // Pin positions and widths
    // ------------------------------------------------------------------
    localparam int ADDR_W        = 26;
    localparam int DATA_W        = 32;
    localparam int NCS           = 8;
    localparam int PIN_SDRAM_CS  = 1;
    localparam int PIN_NAND_CS   = 3;
    localparam int PIN_CARD_CS0  = 4;
    localparam int PIN_CARD_CS1  = 5;
    localparam int PIN_FLASH_ALE = 21;
    localparam int PIN_FLASH_CLE = 22;
    localparam int PIN_CARD_REG  = 22;
    localparam int PIN_CARD_DIR  = 25;
    localparam int PIN_BA0       = 16;
    localparam int PIN_BA1       = 17;
    localparam int FLOAT_CYCLES  = 2;
    localparam logic [7:0] CS_IDLE = 8'hff;

    // Static controller outputs
    typedef struct packed {
        logic [25:0] addr;
        logic [7:0]  cs_n;
        logic        rd_n;
        logic        wr_n;
        logic [3:0]  be_n;
        logic        active;
        ebpm_dev_type dev;
    } ebpm_smc_type;

    // SDRAM controller outputs
    typedef struct packed {
        logic [12:0] addr;
        logic [1:0]  bank;
        logic [3:0]  dqm;
        logic        cs_n;
        logic        active;
    } ebpm_sdr_type;

    // Flash strobes
    typedef struct packed {
        logic ale;
        logic cle;
        logic re_n;
        logic we_n;
    } ebpm_nand_type;

    // Shared pins
    typedef struct packed {
        logic [25:0] a;
        logic        sdram_addr_ten;
        logic [7:0]  cs_n;
        logic        rd_n;
        logic        wr0_n;
        logic        wr1_n;
        logic        wr3_n;
        logic        nand_oe_n;
        logic        nand_we_n;
        logic        ce1_n;
        logic        ce2_n;
    } ebpm_pins_type;

endpackage

// *** verilog/ebpm_owner.sv ***
// Pin owner arbiter with a float gap between owner changes.
// Assumes controllers raise active only while their access is on the pins.
`timescale 1ns/1ps
module ebpm_owner
    import ebpm_pkg::*;
(
    input  wire logic           CLK,
    input  wire logic           RST_N,
    input  wire logic           smc_active,
    input  wire logic           sdr_active,
    output ebpm_owner_type      owner,
    output logic                gap
);
    ebpm_owner_type owner_reg, owner_next;
    logic [1:0]     gap_reg, gap_next;

    // ------------------------------------------------------------------
    // Next owner
    // ------------------------------------------------------------------
    always_comb begin
        owner_next = owner_reg;
        gap_next   = (gap_reg != 2'h0) ? gap_reg - 2'h1 : 2'h0;
        unique case (owner_reg)
            OWN_STATIC: begin
                if (sdr_active && !smc_active && gap_reg == 2'h0) begin
                    owner_next = OWN_SDRAM;
                    gap_next   = 2'(FLOAT_CYCLES);
                end
            end
            OWN_SDRAM: begin
                if (!sdr_active && gap_reg == 2'h0) begin
                    owner_next = OWN_STATIC;
                    gap_next   = 2'(FLOAT_CYCLES);
                end
            end
            default: owner_next = OWN_STATIC;
        endcase
    end

    // Registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            owner_reg <= OWN_STATIC;
            gap_reg   <= 2'h0;
        end else begin
            owner_reg <= owner_next;
            gap_reg   <= gap_next;
        end
    end

    assign owner = owner_reg;
    assign gap   = (gap_reg != 2'h0);
endmodule

// *** verilog/ebpm_route.sv ***
// Static pin routing: address shift and strobe placement per device kind.
// Assumes static address and strobes are settled each cycle.
`timescale 1ns/1ps
module ebpm_route
    import ebpm_pkg::*;
(
    input  ebpm_smc_type        static_mem_ctrl,
    input  ebpm_nand_type       nand_in,
    output logic [25:0]         a,
    output logic                wr0_n,
    output logic                wr1_n,
    output logic                wr3_n,
    output logic                ce1_n,
    output logic                ce2_n
);
    logic [25:0] ad;

    // ------------------------------------------------------------------
    // Routing per device kind
    // ------------------------------------------------------------------
    always_comb begin
        ad    = static_mem_ctrl.addr;
        a     = ad;
        wr0_n = 1'b1;
        wr1_n = 1'b1;
        wr3_n = 1'b1;
        ce1_n = 1'b1;
        ce2_n = 1'b1;
        unique case (static_mem_ctrl.dev)
            DEV_S8: begin
                a     = ad;
                wr0_n = static_mem_ctrl.wr_n;
            end
            DEV_S2X8: begin
                a     = {1'b0, ad[25:1]};
                wr0_n = static_mem_ctrl.wr_n | static_mem_ctrl.be_n[0];
                wr1_n = static_mem_ctrl.wr_n | static_mem_ctrl.be_n[1];
            end
            DEV_S16: begin
                a     = {1'b0, ad[25:1]};
                a[0]  = static_mem_ctrl.be_n[0];
                a[1]  = ad[1];
                wr0_n = static_mem_ctrl.wr_n;
                wr1_n = static_mem_ctrl.be_n[1];
            end
            DEV_S4X8: begin
                a     = {2'h0, ad[25:2]};
                a[0]  = 1'b1;
                a[1]  = static_mem_ctrl.wr_n | static_mem_ctrl.be_n[2];
                wr0_n = static_mem_ctrl.wr_n | static_mem_ctrl.be_n[0];
                wr1_n = static_mem_ctrl.wr_n | static_mem_ctrl.be_n[1];
                wr3_n = static_mem_ctrl.wr_n | static_mem_ctrl.be_n[3];
            end
            DEV_S2X16, DEV_S32: begin
                a     = {2'h0, ad[25:2]};
                a[0]  = static_mem_ctrl.be_n[0];
                a[1]  = static_mem_ctrl.be_n[2];
                wr0_n = static_mem_ctrl.wr_n;
                wr1_n = static_mem_ctrl.be_n[1];
                wr3_n = static_mem_ctrl.be_n[3];
            end
            DEV_NAND: begin
                a                = ad;
                a[PIN_FLASH_ALE] = nand_in.ale;
                a[PIN_FLASH_CLE] = nand_in.cle;
            end
            DEV_CARD, DEV_CARDIDE: begin
                a[PIN_CARD_REG]  = ad[PIN_CARD_REG];
                a[PIN_CARD_DIR]  = static_mem_ctrl.wr_n;
                wr0_n            = static_mem_ctrl.wr_n;
                wr1_n            = static_mem_ctrl.rd_n;
                wr3_n            = static_mem_ctrl.wr_n;
                ce1_n            = static_mem_ctrl.be_n[0];
                ce2_n            = static_mem_ctrl.be_n[1];
            end
            default: begin
                a = ad;
            end
        endcase
    end
endmodule

// *** testbench/ebpm_props.sv ***
// Checker of the pin multiplexer: routing of static, flash and card pins and the owner gap.
// Assumes it is bound to ebpm_top and sees only its ports.
`timescale 1ns/1ps
module ebpm_props
    import ebpm_pkg::*;
(
    input wire logic     CLK,
    input wire logic     RST_N,
    input ebpm_smc_type  SMC_IN,
    input ebpm_sdr_type  SDR_IN,
    input ebpm_nand_type NAND_IN,
    input wire logic     SDR_REFRESH,
    input wire logic     D_OE,
    input ebpm_pins_type PINS,
    input wire logic     SMC_STALL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic st_go;
    // Static access routed this cycle
    assign st_go = SMC_IN.active && !SMC_STALL;
    // ------------------------------------------------------------------
    // Static routing
    // ------------------------------------------------------------------
    s8_addr_a: assert property (st_go && SMC_IN.dev == DEV_S8 |=>
        PINS.a == $past(SMC_IN.addr) && PINS.rd_n == $past(SMC_IN.rd_n))
        else $error("static 8-bit pins wrong");
    cs_follow_a: assert property (st_go |=>
        {PINS.cs_n[7:2], PINS.cs_n[0]} == $past({SMC_IN.cs_n[7:2], SMC_IN.cs_n[0]}))
        else $error("chip selects wrong");
    lane_four_a: assert property (st_go && SMC_IN.dev == DEV_S4X8 |=>
        PINS.a[0] && PINS.a[1] == $past(SMC_IN.wr_n | SMC_IN.be_n[2]))
        else $error("byte lane strobe wrong");
    nand_latch_a: assert property (st_go && SMC_IN.dev == DEV_NAND |=>
        PINS.a[22:21] == $past({NAND_IN.cle, NAND_IN.ale}) && PINS.nand_oe_n == $past(NAND_IN.re_n))
        else $error("flash latch pins wrong");
    card_dir_a: assert property (st_go && SMC_IN.dev == DEV_CARD |=>
        PINS.a[25] == $past(SMC_IN.wr_n) && PINS.wr1_n == $past(SMC_IN.rd_n))
        else $error("card direction pins wrong");
    ide_read_a: assert property (st_go && SMC_IN.dev == DEV_CARDIDE |=> PINS.rd_n)
        else $error("read pin active in ide mode");
    // ------------------------------------------------------------------
    // Ownership
    // ------------------------------------------------------------------
    sdr_cs_a: assert property (SDR_IN.active |=> PINS.cs_n[1] == $past(SDR_IN.cs_n))
        else $error("sdram select wrong");
    take_gap_a: assert property (!SMC_STALL && SDR_IN.active && !SDR_REFRESH && !SMC_IN.active |=>
        SMC_STALL [*2])
        else $error("owner change without gap");
    gap_float_a: assert property ($rose(SMC_STALL) |=> !D_OE)
        else $error("data driven in gap");
    refresh_free_a: assert property (!SMC_STALL && SDR_REFRESH |=> !SMC_STALL)
        else $error("refresh stalled static");
    idle_static_a: assert property (!SMC_STALL && !(SDR_IN.active && !SDR_REFRESH) |=> !SMC_STALL)
        else $error("owner left static");
endmodule
bind ebpm_top ebpm_props ebpm_props_inst (.CLK(CLK), .RST_N(RST_N), .SMC_IN(SMC_IN), .SDR_IN(SDR_IN),
    .NAND_IN(NAND_IN), .SDR_REFRESH(SDR_REFRESH), .D_OE(D_OE), .PINS(PINS), .SMC_STALL(SMC_STALL));

// *** testbench/ebpm_ext_mem.sv ***
// Model of the external memories on the shared pins.
// Assumes the board wiring of each device matches its width and kind.
`timescale 1ns/1ps
module ebpm_ext_mem
    import ebpm_pkg::*;
(
    input wire logic     CLK,
    input ebpm_pins_type PINS,
    input wire logic     D_OE,
    output logic [31:0]  D_IN
);
    logic [31:0] last = 32'h0;
    // Read data from address; released bus: low half pulled up, high half inverted
    always @(posedge CLK) begin
        if (!PINS.rd_n && !D_OE) last <= {6'h00, PINS.a} ^ 32'h3c3c0000;
        else last <= {~last[31:16], 16'hffff};
    end
    assign D_IN = last;
endmodule

// *** testbench/ebpm_top_tb_top.sv ***
// Testbench of the pin multiplexer: static kinds, refresh, sdram ownership.
// Assumes the design and the bound checker are compiled first.
`timescale 1ns/1ps
module ebpm_top_tb_top;
    import ebpm_pkg::*;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic refr = 1'b0;
    logic sdoe = 1'b0;
    logic ddoe = 1'b0;
    logic [31:0] swd = 32'h0;
    logic [31:0] dwd = 32'h0;
    logic [31:0] d_in, d_out, rdata;
    logic d_oe, stall;
    logic [15:0] lfsr = 16'h005a;
    ebpm_smc_type static_mem_ctrl;
    ebpm_sdr_type sdr;
    ebpm_nand_type nd;
    ebpm_pins_type pins, e, m;
    ebpm_pins_type eq[$];
    ebpm_pins_type mq[$];
    logic [64:0] ed;
    logic [64:0] dq[$];
    int bad_count = 0;
    int n_compared = 0;
    // Clock
    always #2 CLK = ~CLK;
    ebpm_top ebpm_top_inst (.CLK(CLK), .RST_N(RST_N), .SMC_IN(static_mem_ctrl), .SDR_IN(sdr), .NAND_IN(nd),
        .SDR_REFRESH(refr), .SMC_WDATA(swd), .SDR_WDATA(dwd), .SMC_DOE(sdoe), .SDR_DOE(ddoe),
        .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .RDATA(rdata), .PINS(pins), .SMC_STALL(stall));
    ebpm_ext_mem ebpm_ext_mem_inst (.CLK(CLK), .PINS(pins), .D_OE(d_oe), .D_IN(d_in));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    task automatic note();
        eq.push_back(e);
        mq.push_back(m);
        dq.push_back(ed);
    endtask
    task automatic cmp_pins(ebpm_pins_type ex, ebpm_pins_type mk);
        n_compared++;
        if ((pins & mk) !== (ex & mk)) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, pins & mk, ex & mk);
        end
    endtask
    task automatic cmp_bit(logic got, logic ex);
        n_compared++;
        if (got !== ex) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, ex);
        end
    endtask
    // Data lanes: drive enable, write data and captured read data
    task automatic cmp_data(logic [64:0] ex);
        n_compared++;
        if ({d_oe, d_out, rdata} !== ex) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, {d_oe, d_out, rdata}, ex);
        end
    endtask
    // Static access with random fields, expectation by kind
    task automatic step_static(ebpm_dev_type dv);
        logic [31:0] r;
        logic [15:0] q;
        @(negedge CLK);
        r = {rnd(), rnd()};
        q = rnd();
        static_mem_ctrl = '{addr: r[25:0], cs_n: q[7:0], rd_n: ~r[30], wr_n: r[30], be_n: r[29:26], active: 1'b1, dev: dv};
        nd = q[11:8];
        swd = r;
        sdoe = ~r[30];
        ed = {sdoe, swd, d_in};
        e = '1;
        m = '0;
        m.a = '1;
        m.cs_n = 8'hfd;
        m.rd_n = 1'b1;
        e.cs_n = static_mem_ctrl.cs_n;
        e.rd_n = static_mem_ctrl.rd_n | (dv == DEV_CARDIDE);
        e.a = (dv == DEV_S8) ? static_mem_ctrl.addr : (dv <= DEV_S16) ? static_mem_ctrl.addr >> 1 : static_mem_ctrl.addr >> 2;
        case (dv)
            DEV_S2X8: begin
                {m.wr0_n, m.wr1_n} = 2'h3;
                e.wr0_n = static_mem_ctrl.wr_n | static_mem_ctrl.be_n[0];
                e.wr1_n = static_mem_ctrl.wr_n | static_mem_ctrl.be_n[1];
            end
            DEV_S16: begin
                m.wr1_n = 1'b1;
                e.a[1:0] = {static_mem_ctrl.addr[1], static_mem_ctrl.be_n[0]};
                e.wr1_n = static_mem_ctrl.be_n[1];
            end
            DEV_S4X8: begin
                {m.wr0_n, m.wr1_n, m.wr3_n} = 3'h7;
                e.a[1:0] = {static_mem_ctrl.wr_n | static_mem_ctrl.be_n[2], 1'b1};
                {e.wr0_n, e.wr1_n, e.wr3_n} = {3{static_mem_ctrl.wr_n}} | {static_mem_ctrl.be_n[0], static_mem_ctrl.be_n[1], static_mem_ctrl.be_n[3]};
            end
            DEV_S2X16, DEV_S32: begin
                {m.wr0_n, m.wr1_n, m.wr3_n} = 3'h7;
                e.a[1:0] = {static_mem_ctrl.be_n[2], static_mem_ctrl.be_n[0]};
                {e.wr0_n, e.wr1_n, e.wr3_n} = {static_mem_ctrl.wr_n, static_mem_ctrl.be_n[1], static_mem_ctrl.be_n[3]};
            end
            DEV_NAND: begin
                m.a = 26'h0600000;
                {m.nand_oe_n, m.nand_we_n} = 2'h3;
                e.a[22:21] = {nd.cle, nd.ale};
                {e.nand_oe_n, e.nand_we_n} = {nd.re_n, nd.we_n};
            end
            DEV_CARD, DEV_CARDIDE: begin
                m.a = 26'h24007ff;
                {m.wr0_n, m.wr1_n, m.wr3_n, m.ce1_n, m.ce2_n} = 5'h1f;
                e.a[10:0] = static_mem_ctrl.addr[10:0];
                {e.a[25], e.a[22]} = {static_mem_ctrl.wr_n, static_mem_ctrl.addr[22]};
                {e.wr0_n, e.wr1_n, e.wr3_n} = {static_mem_ctrl.wr_n, static_mem_ctrl.rd_n, static_mem_ctrl.wr_n};
                {e.ce1_n, e.ce2_n} = {static_mem_ctrl.be_n[0], static_mem_ctrl.be_n[1]};
            end
            DEV_SDRAM: begin
                e.a = static_mem_ctrl.addr;
            end
            default: ;
        endcase
        note();
    endtask
    // SDRAM cycle with random fields
    task automatic step_sdr();
        logic [31:0] r;
        @(negedge CLK);
        r = {rnd(), rnd()};
        sdr = '{addr: r[12:0], bank: r[14:13], dqm: r[18:15], cs_n: 1'b0, active: 1'b1};
        dwd = r;
        ddoe = r[20];
        ed = {ddoe, dwd, d_in};
        e = '1;
        m = '0;
        m.a = 26'h0036fff;
        {m.sdram_addr_ten, m.wr1_n, m.wr3_n} = 3'h7;
        m.cs_n = 8'h02;
        e.a[11:0] = {sdr.addr[9:0], sdr.dqm[2], sdr.dqm[0]};
        e.a[17:13] = {sdr.bank, 1'b1, sdr.addr[12:11]};
        {e.sdram_addr_ten, e.wr1_n, e.wr3_n} = {sdr.addr[10], sdr.dqm[1], sdr.dqm[3]};
        e.cs_n[1] = 1'b0;
        note();
        cmp_bit(stall, 1'b1);
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Result watcher: oldest note against the pins
    // ------------------------------------------------------------------
    always @(posedge CLK) begin
        #1;
        if (eq.size() > 0) begin
            cmp_pins(eq.pop_front(), mq.pop_front());
            cmp_data(dq.pop_front());
        end
    end
    // Watchdog
    initial begin
        #20000;
        bad_count++;
        summarize();
    end
    // Main sequence
    initial begin
        static_mem_ctrl = '0;
        static_mem_ctrl.cs_n = CS_IDLE;
        sdr = '0;
        sdr.cs_n = 1'b1;
        nd = '0;
        repeat (2) @(posedge CLK);
        @(negedge CLK) RST_N = 1'b1;
        for (int i = 0; i < 10; i++) repeat (4) step_static(ebpm_dev_type'(i[3:0]));
        step_static(DEV_S8);
        @(negedge CLK);
        static_mem_ctrl.active = 1'b0;
        e.rd_n = 1'b1;
        e.cs_n = CS_IDLE;
        ed[64] = 1'b0;
        note();
        @(negedge CLK);
        sdr.active = 1'b1;
        refr = 1'b1;
        repeat (3) step_static(DEV_S32);
        cmp_bit(stall, 1'b0);
        @(negedge CLK);
        static_mem_ctrl.active = 1'b0;
        refr = 1'b0;
        repeat (4) begin
            @(negedge CLK);
            static_mem_ctrl.active = 1'b1;
            cmp_bit(stall, 1'b1);
        end
        repeat (4) step_sdr();
        @(negedge CLK);
        sdr.active = 1'b0;
        sdr.cs_n = 1'b1;
        for (int k = 0; k < 8 && stall !== 1'b0; k++) @(negedge CLK);
        cmp_bit(stall, 1'b0);
        repeat (2) step_static(DEV_S16);
        repeat (3) @(posedge CLK);
        summarize();
    end
endmodule
